/* File: rtl/olsm_pkg.sv */
// Package for the open-load status and oscillator modulation block
package olsm_pkg;
   // Status register layout
   localparam int          STATUS_WIDTH   = 8;
   localparam int          FAULT_COUNT    = 6;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam logic [1:0]  RESERVED_VALUE = 2'h0;
   localparam int          BIT_B3_HIGH    = 5;
   localparam int          BIT_B3_LOW     = 4;
   localparam int          BIT_B2_HIGH    = 3;
   localparam int          BIT_B2_LOW     = 2;
   localparam int          BIT_B1_HIGH    = 1;
   localparam int          BIT_B1_LOW     = 0;
   // Clear bit position in the address byte
   localparam int          CLEAR_BIT      = 7;
   // Oscillator base and modulation rates
   localparam int          BASE_HZ        = 8_000_000;
   localparam int          RATE1_MHZ      = 15_625_000;  // 15.625 kHz in mHz
   localparam int          RATE2_MHZ      = 31_250_000;  // 31.25 kHz in mHz
   localparam int          RATE3_MHZ      = 62_500_000;  // 62.5 kHz in mHz
   localparam int          SYS_HZ         = 125_000_000;
   // Half periods of the modulation triangle, in system clocks
   localparam int          HALF1 = SYS_HZ / (RATE1_MHZ / 1000) / 2;
   localparam int          HALF2 = SYS_HZ / (RATE2_MHZ / 1000) / 2;
   localparam int          HALF3 = SYS_HZ / (RATE3_MHZ / 1000) / 2;
   localparam logic [11:0] HALF1_CYC = 12'(HALF1);
   localparam logic [11:0] HALF2_CYC = 12'(HALF2);
   localparam logic [11:0] HALF3_CYC = 12'(HALF3);

   // Modulation select encoding
   typedef enum logic [1:0] {
      OLSM_MOD_OFF  = 2'h0,
      OLSM_MOD_SLOW = 2'h1,
      OLSM_MOD_MID  = 2'h2,
      OLSM_MOD_FAST = 2'h3
   } olsm_mod_type;

   // Host access strobe with its address byte
   typedef struct packed {
      logic       strobe;
      logic [7:0] addressByte;
   } olsm_access_type;
endpackage

/* File: rtl/olsm_status.sv */
// Open-load fault status register and oscillator modulation control
//
// Behaviour
// RQ1: Bits 7 and 6 of the status register always read zero.
// RQ2: Bit 5 latches bridge 3 high open load, bit 4 bridge 3 low.
// RQ3: Bit 3 latches bridge 2 high open load, bit 2 bridge 2 low.
// RQ4: Bit 1 latches bridge 1 high open load, bit 0 bridge 1 low.
// RQ5: After reset all fault bits are zero until a detection sets them.
// RQ6: Internal 8 MHz oscillator frequency can be modulated to spread emissions.
// RQ7: Select 00 off, 01 15.625 kHz, 10 31.25 kHz, 11 62.5 kHz.
// RQ8: Access with address bit 7 set clears the latched bits.
// RQ9: Latched bits are never cleared by the device itself.
// RQ10: Load error flag is OR of all open-load and overcurrent bits.
// RQ11: Access with clear bit zero returns bits unchanged.
`timescale 1ns/1ns
`default_nettype none
module olsm_status (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   // Open-load detector inputs, pulses or levels from the analog side
   input  wire logic [5:0]                 openLoadDetect,
   // Overcurrent status bits from the neighbouring register
   input  wire logic [5:0]                 overcurrentStatus,
   // Host access from the serial frame decoder
   input  wire olsm_pkg::olsm_access_type  hostAccess,
   // Modulation select written by the host
   input  wire olsm_pkg::olsm_mod_type     oscillator_modulation_select,
   // Register read data and flags
   output logic [7:0]                      readData,
   output logic                            global_load_error_flag,
   // Frequency trim offset for the oscillator, signed triangle step
   output logic signed [7:0]               oscillatorTrim,
   output logic                            modulationActive
);
   import olsm_pkg::*;

   logic [5:0]        faultBits;
   logic [5:0]        next_faultBits;
   logic [7:0]        next_readData;
   logic [11:0]       dwellCount;
   logic [11:0]       next_dwellCount;
   logic signed [7:0] next_oscillatorTrim;
   logic              rampUp;
   logic              next_rampUp;
   logic [11:0]       halfPeriod;
   logic              clearRequest;

   // Host clear comes with the address bit 7 set
   assign clearRequest = hostAccess.strobe &&
                         hostAccess.addressByte[CLEAR_BIT]; // RQ8

   // Latch faults; a new detection wins over a clear in the same cycle
   always_comb begin
      next_faultBits = faultBits;
      if (clearRequest) begin
         next_faultBits = '0; // RQ8
      end
      next_faultBits = next_faultBits | openLoadDetect; // RQ2 RQ3 RQ4 RQ9
   end

   // Read data is captured at the access, before any clear takes effect
   always_comb begin
      next_readData = readData;
      if (hostAccess.strobe) begin
         next_readData = {RESERVED_VALUE, faultBits}; // RQ1 RQ11
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         faultBits <= STATUS_RESET[5:0]; // RQ5
         readData  <= STATUS_RESET;
      end else begin
         faultBits <= next_faultBits;
         readData  <= next_readData;
      end
   end

   // Load error follows the latched and overcurrent bits so it drops once all are clear
   assign global_load_error_flag = |{faultBits, overcurrentStatus}; // RQ10

   // Clocks per ramp half sets the triangle rate; the trim steps every clock except the turnaround clock
   always_comb begin
      unique case (oscillator_modulation_select)
         OLSM_MOD_SLOW: halfPeriod = HALF1_CYC; // RQ7
         OLSM_MOD_MID:  halfPeriod = HALF2_CYC; // RQ7
         OLSM_MOD_FAST: halfPeriod = HALF3_CYC; // RQ7
         OLSM_MOD_OFF:  halfPeriod = 12'h0000;
      endcase
   end

   // Triangle sweep of the trim around the 8 MHz base; off parks at zero
   always_comb begin
      next_dwellCount     = dwellCount;
      next_oscillatorTrim = oscillatorTrim;
      next_rampUp         = rampUp;
      if (oscillator_modulation_select == OLSM_MOD_OFF) begin
         next_dwellCount     = '0;
         next_oscillatorTrim = '0; // RQ7
         next_rampUp         = 1'b1;
      end else if (dwellCount >= halfPeriod - 12'h0001) begin
         next_dwellCount = '0;
         next_rampUp     = ~rampUp; // RQ6
      end else begin
         next_dwellCount     = dwellCount + 12'h0001;
         next_oscillatorTrim = rampUp ? oscillatorTrim + 8'sh01
                                      : oscillatorTrim - 8'sh01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dwellCount     <= '0;
         oscillatorTrim <= '0;
         rampUp         <= 1'b1;
      end else begin
         dwellCount     <= next_dwellCount;
         oscillatorTrim <= next_oscillatorTrim;
         rampUp         <= next_rampUp;
      end
   end

   assign modulationActive = (oscillator_modulation_select != OLSM_MOD_OFF);

   // Checks
   property p_reserved_zero;
      @(posedge sys_clk) disable iff (reset)
      readData[7:6] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // RQ1
      else $error("reserved bits not zero");

   property p_b3_set;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B3_HIGH] |=> faultBits[BIT_B3_HIGH];
   endproperty
   a_b3_set: assert property (p_b3_set) // RQ2
      else $error("bridge 3 high fault not latched");

   property p_b3_low;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B3_LOW] |=> faultBits[BIT_B3_LOW];
   endproperty
   a_b3_low: assert property (p_b3_low) // RQ2
      else $error("bridge 3 low fault not latched");

   property p_b2_set;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B2_LOW] |=> faultBits[BIT_B2_LOW];
   endproperty
   a_b2_set: assert property (p_b2_set) // RQ3
      else $error("bridge 2 low fault not latched");

   property p_b2_high;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B2_HIGH] |=> faultBits[BIT_B2_HIGH];
   endproperty
   a_b2_high: assert property (p_b2_high) // RQ3
      else $error("bridge 2 high fault not latched");

   property p_b1_set;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B1_HIGH] |=> faultBits[BIT_B1_HIGH];
   endproperty
   a_b1_set: assert property (p_b1_set) // RQ4
      else $error("bridge 1 high fault not latched");

   property p_b1_low;
      @(posedge sys_clk) disable iff (reset)
      openLoadDetect[BIT_B1_LOW] |=> faultBits[BIT_B1_LOW];
   endproperty
   a_b1_low: assert property (p_b1_low) // RQ4
      else $error("bridge 1 low fault not latched");

   property p_reset_zero;
      @(posedge sys_clk) reset |=> faultBits == 6'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero) // RQ5
      else $error("faults not zero after reset");

   property p_clear;
      @(posedge sys_clk) disable iff (reset)
      clearRequest && openLoadDetect == 6'h00 |=> faultBits == 6'h00;
   endproperty
   a_clear: assert property (p_clear) // RQ8
      else $error("clear did not empty faults");

   property p_hold;
      @(posedge sys_clk) disable iff (reset)
      !clearRequest |=> (faultBits & $past(faultBits)) == $past(faultBits);
   endproperty
   a_hold: assert property (p_hold) // RQ9
      else $error("fault dropped without clear");

   property p_read_keeps;
      @(posedge sys_clk) disable iff (reset)
      hostAccess.strobe && !clearRequest
      |=> readData[5:0] == $past(faultBits)
          && (faultBits & $past(faultBits)) == $past(faultBits);
   endproperty
   a_read_keeps: assert property (p_read_keeps) // RQ11
      else $error("plain read changed faults");

   property p_load_error;
      @(posedge sys_clk) disable iff (reset)
      global_load_error_flag == (faultBits != 6'h00
                                 || overcurrentStatus != 6'h00);
   endproperty
   a_load_error: assert property (p_load_error) // RQ10
      else $error("load error flag mismatch");

   property p_off_parks;
      @(posedge sys_clk) disable iff (reset)
      oscillator_modulation_select == OLSM_MOD_OFF ##1
      oscillator_modulation_select == OLSM_MOD_OFF
      |-> oscillatorTrim == 8'sh00;
   endproperty
   a_off_parks: assert property (p_off_parks) // RQ7
      else $error("trim not parked when off");

   c_latch: cover property (@(posedge sys_clk) openLoadDetect != 6'h00);
   c_clear: cover property (@(posedge sys_clk) clearRequest
                            && faultBits != 6'h00);
   c_fast:  cover property (@(posedge sys_clk)
                            oscillator_modulation_select == OLSM_MOD_FAST
                            && !rampUp);
endmodule
`default_nettype wire

/* File: tb/olsm_host_model.sv */
// Host model that issues status register accesses
`timescale 1ns/1ns
`default_nettype none
module olsm_host_model (
   // Clock
   input  wire logic                    sys_clk,
   // Access strobe out, register data back
   output var olsm_pkg::olsm_access_type hostAccess,
   input  wire logic [7:0]              readData
);
   import olsm_pkg::*;
   initial hostAccess = '{strobe: 1'b0, addressByte: 8'h00};
   // One cycle strobe; answer is taken one edge after the strobe edge
   task automatic access(input logic clear, output logic [7:0] data);
      @(negedge sys_clk);
      hostAccess = '{strobe: 1'b1, addressByte: {clear, 7'h01}};
      @(negedge sys_clk);
      data = readData;
      // Released address is inverted so a stale byte never looks valid
      hostAccess = '{strobe: 1'b0, addressByte: ~hostAccess.addressByte};
   endtask
endmodule
`default_nettype wire

/* File: tb/olsm_status_tb_top.sv */
// Self-checking bench for the open-load status and modulation block
`timescale 1ns/1ns
`default_nettype none
module olsm_status_tb_top;
   import olsm_pkg::*;
   logic              sys_clk = 1'b0;
   logic              reset = 1'b1;
   logic [5:0]        openLoadDetect = 6'h00;
   logic [5:0]        overcurrentStatus = 6'h00;
   olsm_access_type   hostAccess;
   olsm_mod_type      modSelect = OLSM_MOD_OFF;
   logic [7:0]        readData;
   logic [7:0]        rd;
   logic              flag;
   logic              active;
   logic signed [7:0] trim;
   int                err_total = 0;
   int                checks_done = 0;
   int                cycles = 0;

   olsm_status u_olsm_status (.sys_clk(sys_clk), .reset(reset),
      .openLoadDetect(openLoadDetect), .overcurrentStatus(overcurrentStatus),
      .hostAccess(hostAccess), .oscillator_modulation_select(modSelect),
      .readData(readData), .global_load_error_flag(flag),
      .oscillatorTrim(trim), .modulationActive(active));
   olsm_host_model u_olsm_host_model (.sys_clk(sys_clk),
      .hostAccess(hostAccess), .readData(readData));

   // Clock and hang guard; the tests need about 2430 cycles
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         complete_run();
      end
   end

   // Compare tasks for 8-bit and 1-bit results, a read-and-compare, and the final report
   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rdchk(input logic clr, input logic [7:0] e, input string nm);
      u_olsm_host_model.access(clr, rd);
      chk8(nm, e, rd);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      rdchk(1'b0, 8'h00, "reset value");
      chk1("flag idle", 1'b0, flag);
      // Each detector pulse latches its own bit until a clear
      for (int i = 0; i < 6; i++) begin
         @(negedge sys_clk);
         openLoadDetect = 6'h01 << i;
         @(negedge sys_clk);
         openLoadDetect = 6'h00;
         repeat (50) @(negedge sys_clk);
         rdchk(1'b0, 8'h01 << i, "plain read");
         chk1("flag set", 1'b1, flag);
         rdchk(1'b1, 8'h01 << i, "clear read");
         rdchk(1'b0, 8'h00, "after clear");
         chk1("flag cleared", 1'b0, flag);
      end
      // All bits at once; a detection in the clearing cycle must survive
      openLoadDetect = 6'h3f;
      @(negedge sys_clk);
      openLoadDetect = 6'h00;
      rdchk(1'b0, 8'h3f, "all faults");
      fork
         u_olsm_host_model.access(1'b1, rd);
         begin
            @(negedge sys_clk);
            openLoadDetect = 6'h04;
            @(negedge sys_clk);
            openLoadDetect = 6'h00;
         end
      join
      chk8("old value on clear", 8'h3f, rd);
      rdchk(1'b1, 8'h04, "set beats clear");
      // A reset in mid-run must drop latched faults
      openLoadDetect = 6'h3f;
      @(negedge sys_clk);
      openLoadDetect = 6'h00;
      chk1("flag before reset", 1'b1, flag);
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      rdchk(1'b0, 8'h00, "reset clears faults");
      overcurrentStatus = 6'h20;
      @(negedge sys_clk);
      chk1("flag overcurrent", 1'b1, flag);
      overcurrentStatus = 6'h00;
      // Every select code, starting from a stopped sweep each time
      for (int m = 0; m < 4; m++) begin
         modSelect = OLSM_MOD_OFF;
         @(negedge sys_clk);
         modSelect = olsm_mod_type'(m);
         repeat (20) @(negedge sys_clk);
         chk1("modulation active", m != 0, active);
         chk1("trim moving", m != 0, trim !== 8'sh00);
      end
      // Fast sweep peaks one clock before its half period and is back
      // at zero one clock before a full 62.5 kHz period
      repeat (HALF3 - 21) @(negedge sys_clk);
      chk8("trim peak", 8'(HALF3 - 1), trim);
      repeat (HALF3) @(negedge sys_clk);
      chk8("trim period", 8'h00, trim);
      complete_run();
   end
endmodule
`default_nettype wire
